// *** verilog/cdt_timer.sv ***
// Cascadable dual 8-bit timer/counter core with compare, PDO, PWM and PPG logic.
// Assumes prescaler ticks are one-cycle pulses on clk; event pins are asynchronous.
//
// Functional notes
// - Interval mode counts up once per selected prescaled clock tick.
// - Count reaching compare raises match interrupt and clears counter.
// - Counting resumes from zero on its own; period is compare ticks.
// - Compare value has no shadow and acts at once.
// - Each channel offers interval, event, divider and PWM modes.
// - Two channels can be cascaded into one 16-bit timer.
// - Cascade offers timer, event, warm-up, PWM and pulse generation.
// - Cascade takes its clock from the lower channel clock select.
// - Mode codes 000 timer,001 divider,010 PWM,1xx cascade modes,011 reserved.
// - Pin clock select counts falling edges of the event pin.
`default_nettype none
module cdt_timer
  import cdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Prescaler ticks
  input wire logic [6:0] prescaled_tick,
  input wire logic lowfreq_div8_tick,
  input wire logic prescaler_source_select,
  // Event pins
  input wire logic [1:0] event_pin,
  // Channel control, index 0 is the lower channel
  input wire logic [2:0] lower_clock_select,
  input wire logic [2:0] upper_clock_select,
  input wire logic [2:0] lower_mode_select,
  input wire logic [2:0] upper_mode_select,
  input wire logic [1:0] timer_start,
  input wire logic [1:0] flipflop_init_value,
  // Compare values
  input wire logic [1:0][7:0] period_compare_reg,
  input wire logic [1:0][7:0] duty_compare_reg,
  // Results
  output logic [1:0] timer_match_irq,
  output logic [1:0] divider_out_pin,
  output logic [1:0] pwm_out_pin,
  output logic pulse_gen_out_pin,
  output logic [15:0] count_value
);
  // ********************
  // State and helpers
  // ********************
  typedef struct packed {
    logic [1:0][7:0] count;
    logic [1:0][7:0] duty;
    logic [1:0] pin;
    logic [1:0] irq;
  } cdt_state_t;

  cdt_state_t st;
  cdt_state_t next_st;

  function automatic logic [7:0] cdt_bump8(input logic [7:0] v);
    return 8'(v + 8'h01);
  endfunction

  function automatic logic [15:0] cdt_bump16(input logic [15:0] v);
    return 16'(v + 16'h0001);
  endfunction

  logic [6:0] src_vec;
  logic [1:0] tick;
  logic [1:0][2:0] ch_mode;
  logic cascade;
  logic [15:0] cnt16;
  logic [15:0] per16;
  logic [15:0] duty16;

  assign src_vec = {prescaled_tick[6:1],
                    prescaler_source_select ? lowfreq_div8_tick : prescaled_tick[0]};
  assign ch_mode = {upper_mode_select, lower_mode_select};
  assign cascade = upper_mode_select[CDT_MODE_CASCADE_BIT];
  assign cnt16 = {st.count[CDT_UPPER], st.count[CDT_LOWER]};
  assign per16 = {period_compare_reg[CDT_UPPER], period_compare_reg[CDT_LOWER]};
  assign duty16 = {st.duty[CDT_UPPER], st.duty[CDT_LOWER]};

  // ********************
  // Tick selection
  // ********************
  cdt_tick_if lo_if ();
  cdt_tick_if hi_if ();

  assign lo_if.clock_select = lower_clock_select;
  assign lo_if.sources = src_vec;
  assign lo_if.pin_raw = event_pin[CDT_LOWER];
  assign hi_if.clock_select = upper_clock_select;
  assign hi_if.sources = src_vec;
  assign hi_if.pin_raw = event_pin[CDT_UPPER];
  assign tick = {hi_if.tick, lo_if.tick};

  cdt_tick u_tick_lo (.clk(clk), .reset(reset), .link(lo_if));
  cdt_tick u_tick_hi (.clk(clk), .reset(reset), .link(hi_if));

  // ********************
  // Counting
  // ********************
  always_comb begin
    next_st = st;
    next_st.irq = '0;
    if (cascade) begin
      next_st.pin[CDT_LOWER] = ~flipflop_init_value[CDT_LOWER];
      if (!timer_start[CDT_UPPER]) begin
        next_st.count = '0;
        next_st.pin[CDT_UPPER] = ~flipflop_init_value[CDT_UPPER];
        next_st.duty = duty_compare_reg;
      end else if (tick[CDT_LOWER]) begin
        next_st.count = cnt16;
        unique case (upper_mode_select)
          CDT_MODE_PWM16: begin
            next_st.count = cdt_bump16(cnt16);
            if (cdt_bump16(cnt16) == duty16) begin
              next_st.pin[CDT_UPPER] = ~st.pin[CDT_UPPER];
            end
            if (cnt16 == CDT_COUNT16_MAX) begin
              next_st.pin[CDT_UPPER] = ~st.pin[CDT_UPPER];
              next_st.count = '0;
              next_st.irq[CDT_UPPER] = 1'b1;
              next_st.duty = duty_compare_reg;
            end
          end
          CDT_MODE_PPG: begin
            next_st.count = cdt_bump16(cnt16);
            if (cdt_bump16(cnt16) == duty16) begin
              next_st.pin[CDT_UPPER] = ~st.pin[CDT_UPPER];
            end
            if (cdt_bump16(cnt16) == per16) begin
              next_st.pin[CDT_UPPER] = ~st.pin[CDT_UPPER];
              next_st.count = '0;
              next_st.irq[CDT_UPPER] = 1'b1;
              next_st.duty = duty_compare_reg;
            end
          end
          default: begin
            // 16-bit timer, event counter and warm-up
            next_st.count = cdt_bump16(cnt16);
            if (cdt_bump16(cnt16) == per16) begin
              next_st.count = '0;
              next_st.irq[CDT_UPPER] = 1'b1;
            end
          end
        endcase
      end
    end else begin
      for (int ch = 0; ch < CDT_CHANNELS; ch++) begin
        if (!timer_start[ch]) begin
          next_st.count[ch] = '0;
          next_st.pin[ch] = ~flipflop_init_value[ch];
          next_st.duty[ch] = duty_compare_reg[ch];
        end else if (tick[ch]) begin
          unique case (ch_mode[ch])
            CDT_MODE_TIMER, CDT_MODE_DIVIDER: begin
              next_st.count[ch] = cdt_bump8(st.count[ch]);
              if (cdt_bump8(st.count[ch]) == period_compare_reg[ch]) begin
                next_st.count[ch] = '0;
                next_st.irq[ch] = 1'b1;
                if (ch_mode[ch] == CDT_MODE_DIVIDER) begin
                  next_st.pin[ch] = ~st.pin[ch];
                end
              end
            end
            CDT_MODE_PWM8: begin
              next_st.count[ch] = cdt_bump8(st.count[ch]);
              if (cdt_bump8(st.count[ch]) == st.duty[ch]) begin
                next_st.pin[ch] = ~st.pin[ch];
              end
              if (st.count[ch] == CDT_COUNT8_MAX) begin
                next_st.pin[ch] = ~st.pin[ch];
                next_st.count[ch] = '0;
                next_st.irq[ch] = 1'b1;
                next_st.duty[ch] = duty_compare_reg[ch];
              end
            end
            default: begin
              next_st.count[ch] = st.count[ch];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.count <= '0;
      st.duty <= '0;
      st.pin <= {CDT_PIN_RESET, CDT_PIN_RESET};
      st.irq <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer_match_irq = st.irq;
  assign divider_out_pin = st.pin;
  assign pwm_out_pin = st.pin;
  assign pulse_gen_out_pin = st.pin[CDT_UPPER];
  assign count_value = {st.count[CDT_UPPER], st.count[CDT_LOWER]};

  // ********************
  // Checks
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_irq_clears_count: assert property (
    st.irq[CDT_LOWER] && !cascade |-> st.count[CDT_LOWER] == 8'h00)
    else $error("match interrupt without cleared counter");
  a_match_gives_irq: assert property (
    !cascade && timer_start[CDT_LOWER] && tick[CDT_LOWER]
    && lower_mode_select == CDT_MODE_TIMER
    && cdt_bump8(st.count[CDT_LOWER]) == period_compare_reg[CDT_LOWER]
    |=> st.irq[CDT_LOWER] && st.count[CDT_LOWER] == 8'h00)
    else $error("match did not raise interrupt");
  a_count_steps_one: assert property (
    !cascade && timer_start[CDT_LOWER] && tick[CDT_LOWER]
    && lower_mode_select == CDT_MODE_TIMER
    && cdt_bump8(st.count[CDT_LOWER]) != period_compare_reg[CDT_LOWER]
    |=> st.count[CDT_LOWER] == cdt_bump8($past(st.count[CDT_LOWER])))
    else $error("counter did not step by one");
  a_idle_holds_count: assert property (
    !cascade && !tick[CDT_LOWER] && timer_start[CDT_LOWER]
    |=> $stable(st.count[CDT_LOWER]))
    else $error("counter moved without a tick");
  a_restart_from_zero: assert property (
    st.irq[CDT_LOWER] && !cascade && timer_start[CDT_LOWER] && tick[CDT_LOWER]
    && lower_mode_select == CDT_MODE_TIMER && period_compare_reg[CDT_LOWER] != 8'h01
    |=> st.count[CDT_LOWER] == 8'h01)
    else $error("counter did not resume from zero");
  a_compare_immediate: assert property (
    $changed(period_compare_reg[CDT_LOWER]) && !cascade && timer_start[CDT_LOWER]
    && tick[CDT_LOWER] && lower_mode_select == CDT_MODE_TIMER
    && cdt_bump8(st.count[CDT_LOWER]) == period_compare_reg[CDT_LOWER]
    |=> st.irq[CDT_LOWER])
    else $error("new compare value not used at once");
  a_divider_toggle: assert property (
    !cascade && timer_start[CDT_LOWER] && tick[CDT_LOWER]
    && lower_mode_select == CDT_MODE_DIVIDER
    && cdt_bump8(st.count[CDT_LOWER]) == period_compare_reg[CDT_LOWER]
    |=> st.pin[CDT_LOWER] != $past(st.pin[CDT_LOWER]))
    else $error("divider output did not toggle on match");
  a_reserved_holds: assert property (
    !cascade && lower_mode_select == CDT_MODE_RESERVED && timer_start[CDT_LOWER]
    |=> $stable(st.count[CDT_LOWER]))
    else $error("reserved mode counted");
  a_cascade_lower_clock: assert property (
    cascade && !tick[CDT_LOWER] && timer_start[CDT_UPPER] ##1 cascade
    |-> $stable(count_value))
    else $error("cascade counted without lower tick");
  a_cascade_match: assert property (
    cascade && timer_start[CDT_UPPER] && tick[CDT_LOWER]
    && upper_mode_select == CDT_MODE_TIMER16 && cdt_bump16(cnt16) == per16
    |=> st.irq[CDT_UPPER] && count_value == 16'h0000)
    else $error("16-bit match not handled");
  a_stop_clears: assert property (
    !timer_start[CDT_LOWER] && !cascade
    |=> st.count[CDT_LOWER] == 8'h00
    && st.pin[CDT_LOWER] == ~$past(flipflop_init_value[CDT_LOWER]))
    else $error("stopped channel kept a count");

  c_lower_match: cover property (st.irq[CDT_LOWER] ##[1:300] st.irq[CDT_LOWER]);
  c_pwm_cycle: cover property (lower_mode_select == CDT_MODE_PWM8 && st.irq[CDT_LOWER]);
  c_cascade_irq: cover property (cascade && st.irq[CDT_UPPER]);
  c_ppg_irq: cover property (upper_mode_select == CDT_MODE_PPG && st.irq[CDT_UPPER]);
endmodule
`default_nettype wire

// *** verilog/cdt_pkg.sv ***
// Constants shared by the cascadable dual 8-bit timer and its tick selector.
// Assumes one system clock; the prescaler ticks are one-cycle pulses on it.
`default_nettype none
package cdt_pkg;
  localparam int CDT_CHANNELS = 2;
  localparam int CDT_WIDTH = 8;
  localparam int CDT_SOURCES = 7;
  // Mode field encoding
  localparam logic [2:0] CDT_MODE_TIMER = 3'h0;
  localparam logic [2:0] CDT_MODE_DIVIDER = 3'h1;
  localparam logic [2:0] CDT_MODE_PWM8 = 3'h2;
  localparam logic [2:0] CDT_MODE_RESERVED = 3'h3;
  localparam logic [2:0] CDT_MODE_TIMER16 = 3'h4;
  localparam logic [2:0] CDT_MODE_WARMUP = 3'h5;
  localparam logic [2:0] CDT_MODE_PWM16 = 3'h6;
  localparam logic [2:0] CDT_MODE_PPG = 3'h7;
  localparam int CDT_MODE_CASCADE_BIT = 2;
  // Clock select code for the external event pin
  localparam logic [2:0] CDT_CLK_PIN = 3'h7;
  localparam logic [7:0] CDT_COUNT8_MAX = 8'hFF;
  localparam logic [15:0] CDT_COUNT16_MAX = 16'hFFFF;
  // Timer flip-flop resets to 0, pins show its inverse
  localparam logic CDT_PIN_RESET = 1'b1;
  localparam int CDT_LOWER = 0;
  localparam int CDT_UPPER = 1;
endpackage
`default_nettype wire

// *** verilog/cdt_tick_if.sv ***
// Source selection link between the timer core and one tick selector.
// Assumes the source pulses are synchronous to the core clock.
`default_nettype none
interface cdt_tick_if;
  logic [2:0] clock_select;
  logic [6:0] sources;
  logic pin_raw;
  logic tick;
  modport tick_side (input clock_select, input sources, input pin_raw, output tick);
  modport core_side (output clock_select, output sources, output pin_raw, input tick);
endinterface
`default_nettype wire

// *** verilog/cdt_tick.sv ***
// Per-channel count tick: selected prescaler pulse or falling edge of the pin.
// Assumes the event pin is asynchronous to clk.
`default_nettype none
module cdt_tick
  import cdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link to the core
  cdt_tick_if.tick_side link
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic tick;
  } cdt_tick_state_t;

  cdt_tick_state_t st;
  cdt_tick_state_t next_st;

  assign link.tick = st.tick;

  always_comb begin
    next_st = st;
    next_st.sync1 = link.pin_raw;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    if (link.clock_select == CDT_CLK_PIN) begin
      next_st.tick = st.prev & ~st.sync2;
    end else begin
      next_st.tick = link.sources[link.clock_select];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_pin_fall_tick: assert property (
    (link.clock_select == CDT_CLK_PIN) && st.prev && !st.sync2 |=> st.tick)
    else $error("pin falling edge gave no tick");
  a_pin_no_rise: assert property (
    (link.clock_select == CDT_CLK_PIN) && !(st.prev && !st.sync2) |=> !st.tick)
    else $error("tick without a pin falling edge");
endmodule
`default_nettype wire

// *** verification/cdt_timer_tb.sv ***
// Self-checking bench for the dual 8-bit timer core, driven at its plain ports.
// Assumes cdt_pkg and the design files are compiled first; inputs change at negedge.
`default_nettype none
module cdt_timer_tb
  import cdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, lowfreq_div8_tick, prescaler_source_select, pulse_gen_out_pin;
  logic [6:0] prescaled_tick, tick_mask;
  logic [1:0] event_pin, timer_start, flipflop_init_value, pin_phase;
  logic [1:0] timer_match_irq, divider_out_pin, pwm_out_pin;
  logic [2:0] lower_clock_select, upper_clock_select, lower_mode_select, upper_mode_select;
  logic [1:0][7:0] period_compare_reg, duty_compare_reg;
  logic [15:0] count_value;
  logic low_tick_en, pin_run;
  int err_count, comparisons, tick_div, phase, w, k;
  // ***********************************
  // Clock, stimulus sources, instance
  // ***********************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    phase <= (reset || phase + 1 >= tick_div) ? 0 : phase + 1;
    prescaled_tick <= (phase == 0) ? tick_mask : 7'h00;
    lowfreq_div8_tick <= (phase == 0) && low_tick_en;
    pin_phase <= reset ? 2'h0 : pin_phase + 2'h1;
    event_pin <= {2{~pin_run | ~pin_phase[1]}};
  end
  cdt_timer dut (.clk(clk), .reset(reset), .prescaled_tick(prescaled_tick),
    .lowfreq_div8_tick(lowfreq_div8_tick), .prescaler_source_select(prescaler_source_select),
    .event_pin(event_pin), .lower_clock_select(lower_clock_select),
    .upper_clock_select(upper_clock_select), .lower_mode_select(lower_mode_select),
    .upper_mode_select(upper_mode_select), .timer_start(timer_start),
    .flipflop_init_value(flipflop_init_value), .period_compare_reg(period_compare_reg),
    .duty_compare_reg(duty_compare_reg), .timer_match_irq(timer_match_irq),
    .divider_out_pin(divider_out_pin), .pwm_out_pin(pwm_out_pin),
    .pulse_gen_out_pin(pulse_gen_out_pin), .count_value(count_value));
  // ***********************************
  // Access tasks
  // ***********************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic watched(input int sel);
    case (sel)
      0: return timer_match_irq[0];
      1: return timer_match_irq[1];
      2: return divider_out_pin[0];
      3: return ~pwm_out_pin[0];
      default: return ~pulse_gen_out_pin;
    endcase
  endfunction
  // Cycles until the watched signal next rises
  task automatic wait_rise(input int sel, input int limit, output int waited);
    logic prev;
    waited = 0;
    prev = watched(sel);
    while (waited < limit) begin
      @(negedge clk);
      waited++;
      if (watched(sel) === 1'b1 && prev !== 1'b1) break;
      prev = watched(sel);
    end
  endtask
  task automatic period_is(input int sel, input int exp);
    int p;
    wait_rise(sel, 2000, p);
    wait_rise(sel, 2000, p);
    check(16'(p), 16'(exp));
  endtask
  task automatic setup(input logic [2:0] lm, input logic [2:0] um, input logic [2:0] ls,
      input logic [2:0] us, input logic [15:0] per, input logic [1:0] st);
    @(negedge clk);
    timer_start = 2'h0;
    @(negedge clk);
    lower_mode_select = lm;
    upper_mode_select = um;
    lower_clock_select = ls;
    upper_clock_select = us;
    period_compare_reg = per;
    @(negedge clk);
    timer_start = st;
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  // ***********************************
  // Tests
  // ***********************************
  initial begin
    reset = 1'b1;
    tick_mask = 7'h7F;
    tick_div = 1;
    low_tick_en = 1'b0;
    pin_run = 1'b0;
    prescaler_source_select = 1'b0;
    lower_clock_select = 3'h0;
    upper_clock_select = 3'h0;
    lower_mode_select = CDT_MODE_TIMER;
    upper_mode_select = CDT_MODE_TIMER;
    timer_start = 2'h0;
    flipflop_init_value = 2'h0;
    period_compare_reg = 16'h0505;
    duty_compare_reg = 16'h6464;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    check(count_value, 16'h0000);
    setup(CDT_MODE_TIMER, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h0305, 2'h3);
    wait_rise(0, 50, w);
    check({8'h00, count_value[7:0]}, 16'h0000);
    @(negedge clk);
    check({8'h00, count_value[7:0]}, 16'h0001);
    period_is(0, 5);
    period_is(1, 3);
    tick_div = 3;
    period_is(0, 15);
    tick_div = 1;
    end_test("interval");
    for (k = 0; k < 7; k++) begin
      tick_mask = 7'(1 << k);
      setup(CDT_MODE_TIMER, CDT_MODE_TIMER, 3'(k), 3'h0, 16'h0004, 2'h1);
      period_is(0, 4);
      tick_mask = ~7'(1 << k);
      setup(CDT_MODE_TIMER, CDT_MODE_TIMER, 3'(k), 3'h0, 16'h0004, 2'h1);
      wait_rise(0, 20, w);
      check(16'(w), 16'h0014);
    end
    tick_mask = 7'h00;
    low_tick_en = 1'b1;
    prescaler_source_select = 1'b1;
    setup(CDT_MODE_TIMER, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h0004, 2'h1);
    period_is(0, 4);
    low_tick_en = 1'b0;
    prescaler_source_select = 1'b0;
    end_test("clock_select");
    pin_run = 1'b1;
    setup(CDT_MODE_TIMER, CDT_MODE_TIMER, CDT_CLK_PIN, CDT_CLK_PIN, 16'h0203, 2'h3);
    period_is(0, 12);
    period_is(1, 8);
    pin_run = 1'b0;
    end_test("event_pin");
    tick_mask = 7'h7F;
    setup(CDT_MODE_TIMER, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h00C8, 2'h1);
    repeat (10) @(negedge clk);
    period_compare_reg[0] = count_value[7:0] + 8'h02;
    wait_rise(0, 4, w);
    check(16'(w), 16'h0002);
    end_test("compare_immediate");
    timer_start = 2'h0;
    repeat (2) @(negedge clk);
    check(count_value, 16'h0000);
    repeat (8) @(negedge clk);
    check({count_value[7:0], 6'h00, timer_match_irq}, 16'h0000);
    end_test("stop");
    setup(CDT_MODE_RESERVED, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h0004, 2'h1);
    repeat (10) @(negedge clk);
    check(count_value, 16'h0000);
    setup(CDT_MODE_DIVIDER, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h0004, 2'h1);
    period_is(2, 8);
    setup(CDT_MODE_PWM8, CDT_MODE_TIMER, 3'h0, 3'h0, 16'h0004, 2'h1);
    period_is(0, 256);
    wait_rise(3, 300, w);
    check(16'(w), 16'h0064);
    end_test("modes");
    tick_mask = 7'h02;
    for (k = 0; k < 2; k++) begin
      setup(CDT_MODE_TIMER, CDT_MODE_TIMER16 | 3'(k), 3'h1, 3'h2, 16'h0102, 2'h2);
      wait_rise(1, 600, w);
      check(count_value, 16'h0000);
      period_is(1, 258);
    end
    end_test("cascade");
    duty_compare_reg = 16'h0064;
    setup(CDT_MODE_TIMER, CDT_MODE_PPG, 3'h1, 3'h0, 16'h0102, 2'h2);
    period_is(1, 258);
    wait_rise(4, 300, w);
    check(16'(w), 16'h0064);
    setup(CDT_MODE_TIMER, CDT_MODE_PWM16, 3'h1, 3'h0, 16'h0102, 2'h2);
    wait_rise(4, 300, w);
    check(16'(w), 16'h0064);
    check({14'h0000, pwm_out_pin}, 16'h0001);
    check({14'h0000, divider_out_pin}, 16'h0001);
    end_test("pulse_modes");
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
